// File: rtl/spb_cfg.svh
// constants for the serial peripheral port block
`ifndef SPB_CFG_SVH
`define SPB_CFG_SVH
`define SPB_DATA_W       8
`define SPB_NUM_CS       4
`define SPB_DIV_W        8
`define SPB_DIV_RST      8'h02
`define SPB_DIV_ONE      8'h01
`define SPB_CS_IDLE      4'hf
`endif

// File: rtl/spb_pkg.sv
// types for the serial peripheral port block
package spb_pkg;
  typedef enum logic [3:0]
  {
    SPB_IDLE  = 4'b0001,
    SPB_LOAD  = 4'b0010,
    SPB_SHIFT = 4'b0100,
    SPB_DONE  = 4'b1000
  } spb_state_t;
endpackage

// File: rtl/spb_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spb_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// File: rtl/spb_port.sv
// serial peripheral port core with silicon quirks
// Summary of operation
// - in slave mode clearing enable does nothing; only soft reset stops the port.
// - cs0 held with mode-fault detection enabled: transfer never starts.
// - disable keeps tx empty flag; writes while disabled are discarded.
// - dma words written to tx register while disabled are lost.
// - no transmit underrun flag exists; lost slave characters go unreported.
// - mixed divider one, polarity 1, phase bit 0 gives one extra clock pulse.
// - slave rx ready asserts falsely when enabled while its clock pin is high.
`timescale 1ns/1ps
`include "spb_cfg.svh"
module spb_port
#(
  parameter int DW = `SPB_DATA_W,
  parameter int NC = `SPB_NUM_CS
)
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_enable,
  input  wire logic          i_soft_reset_bit,
  input  wire logic          i_master_mode,
  input  wire logic          i_mode_fault_disable,
  input  wire logic          i_cs_hold_after_transfer,
  input  wire logic [1:0]    i_cs_sel,
  input  wire logic [NC-1:0] i_cs_polarity,
  input  wire logic [NC-1:0] i_clock_phase_bit,
  input  wire logic [NC*8-1:0] i_serial_clock_divider,
  input  wire logic          i_tx_wr,
  input  wire logic [DW-1:0] i_tx_data_reg,
  input  wire logic          i_rx_rd,
  input  wire logic          i_sck_pin,
  input  wire logic          i_ss_n_pin,
  input  wire logic          i_miso_pin,
  input  wire logic          i_mosi_pin,
  output logic               o_tx_reg_empty_flag,
  output logic               o_rx_ready_flag,
  output logic [DW-1:0]      o_rx_holding_reg,
  output logic               o_busy,
  output logic               o_sck,
  output logic               o_sck_oe,
  output logic               o_mosi,
  output logic               o_mosi_oe,
  output logic               o_miso,
  output logic               o_miso_oe,
  output logic [NC-1:0]      o_cs_n
);
  localparam int             BCW      = $clog2(DW+1);
  localparam logic [BCW-1:0] LAST_BIT = BCW'(DW);
  spb_pkg::spb_state_t state_q, state_d;
  logic [2:0] pins_s;
  logic       run_q, sck_d1_q, ss_d1_q, extra_q, last_div1_q;
  logic [DW-1:0] txbuf_q, sh_q, rx_q;
  logic       tde_q, rdy_q;
  logic [$clog2(DW+1)-1:0] bit_q;
  logic [7:0] div_cnt_q;
  logic       sck_q;

  spb_sync #(.W(3)) u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_sck_pin, i_ss_n_pin, i_master_mode ? i_miso_pin : i_mosi_pin}),
    .o_sync    (pins_s)
  );

  wire       sck_s   = pins_s[2];
  wire       ss_n_s  = pins_s[1];
  wire       din_s   = pins_s[0];
  wire [7:0] div_sel = i_serial_clock_divider[i_cs_sel*8 +: 8];
  wire       cpol    = i_cs_polarity[i_cs_sel];
  wire       clock_phase_bit   = i_clock_phase_bit[i_cs_sel];
  wire       div_one = (div_sel == `SPB_DIV_ONE);
  wire       hang    = i_cs_hold_after_transfer && !i_mode_fault_disable;
  wire       wr_ok   = i_tx_wr && run_q;
  wire       sck_rise = sck_s && !sck_d1_q;
  wire       ss_fall  = !ss_n_s && ss_d1_q;
  wire       div_tick = (div_cnt_q == 8'h00);
  // mode change between a divide-by-one and another divider under cpol 1 / clock_phase_bit 0
  wire       glitch  = i_master_mode && cpol && !clock_phase_bit && (div_one != last_div1_q);

  // slave mode ignores disable; master follows enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      run_q <= 1'b0;
    else if (i_soft_reset_bit)
      run_q <= 1'b0;
    else if (i_enable)
      run_q <= 1'b1;
    else if (i_master_mode)
      run_q <= 1'b0;
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      spb_pkg::SPB_IDLE:  if (run_q && i_master_mode && !tde_q && !hang) state_d = spb_pkg::SPB_LOAD;
      spb_pkg::SPB_LOAD:  state_d = spb_pkg::SPB_SHIFT;
      spb_pkg::SPB_SHIFT: if (bit_q == LAST_BIT) state_d = spb_pkg::SPB_DONE;
      spb_pkg::SPB_DONE:  state_d = spb_pkg::SPB_IDLE;
      default:            state_d = spb_pkg::SPB_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= spb_pkg::SPB_IDLE;
      sck_d1_q <= 1'b0;
      ss_d1_q <= 1'b1;
      tde_q <= 1'b1;
      rdy_q <= 1'b0;
      txbuf_q <= '0;
      sh_q <= '0;
      rx_q <= '0;
      bit_q <= '0;
      div_cnt_q <= 8'h00;
      sck_q <= 1'b0;
      extra_q <= 1'b0;
      last_div1_q <= 1'b0;
    end
    else if (i_soft_reset_bit)
    begin
      state_q <= spb_pkg::SPB_IDLE;
      tde_q <= 1'b1;
      rdy_q <= 1'b0;
      bit_q <= '0;
      sck_q <= cpol;
      extra_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sck_d1_q <= sck_s;
      ss_d1_q <= ss_n_s;
      last_div1_q <= div_one;
      // write taken only while running; disabled write leaves flag as is
      if (wr_ok)
      begin
        txbuf_q <= i_tx_data_reg;
        tde_q <= 1'b0;
      end
      if (i_rx_rd)
        rdy_q <= 1'b0;
      // slave reloads the shifter on select even with nothing written; no underrun status exists
      if (!i_master_mode && run_q && ss_fall)
      begin
        sh_q <= txbuf_q;
        tde_q <= 1'b1;
        bit_q <= '0;
      end
      // false ready: enabling a slave while its clock pin is high sets the flag
      if (!i_master_mode && (i_enable && !run_q && sck_s))
        rdy_q <= 1'b1;
      if (!i_master_mode && run_q && !ss_n_s && sck_rise)
      begin
        sh_q <= {sh_q[DW-2:0], din_s};
        bit_q <= bit_q + 1'b1;
        if (bit_q == LAST_BIT - 1'b1)
        begin
          rx_q <= {sh_q[DW-2:0], din_s};
          rdy_q <= 1'b1;
          bit_q <= '0;
        end
      end
      if (state_q == spb_pkg::SPB_LOAD)
      begin
        sh_q <= txbuf_q;
        tde_q <= 1'b1;
        bit_q <= '0;
        div_cnt_q <= div_sel;
        sck_q <= cpol;
        extra_q <= glitch;
      end
      if (state_q == spb_pkg::SPB_SHIFT)
      begin
        div_cnt_q <= div_tick ? div_sel - 8'h01 : div_cnt_q - 8'h01;
        // no toggle once the last bit is in, so a divide-by-one frame ends clean
        if (div_tick && bit_q != LAST_BIT)
        begin
          if (extra_q)
          begin
            sck_q <= ~sck_q;
            extra_q <= (sck_q == cpol);
          end
          else
          begin
            sck_q <= ~sck_q;
            if (sck_q != cpol)
            begin
              sh_q <= {sh_q[DW-2:0], din_s};
              bit_q <= bit_q + 1'b1;
            end
          end
        end
      end
      if (state_q == spb_pkg::SPB_DONE)
      begin
        rx_q <= sh_q;
        rdy_q <= 1'b1;
        sck_q <= cpol;
      end
    end
  end

  assign o_tx_reg_empty_flag = tde_q;
  assign o_rx_ready_flag     = rdy_q;
  assign o_rx_holding_reg    = rx_q;
  assign o_busy              = (state_q != spb_pkg::SPB_IDLE);
  assign o_sck               = sck_q;
  assign o_sck_oe            = i_master_mode && run_q;
  assign o_mosi              = sh_q[DW-1];
  assign o_mosi_oe           = i_master_mode && run_q;
  assign o_miso              = sh_q[DW-1];
  assign o_miso_oe           = !i_master_mode && run_q && !ss_n_s;
  assign o_cs_n              = (o_busy || (i_cs_hold_after_transfer && run_q && i_master_mode))
                               ? ~(4'h1 << i_cs_sel) : `SPB_CS_IDLE;

  property p_slave_disable_ignored;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (run_q && !i_master_mode && !i_enable && !i_soft_reset_bit) |=> run_q;
  endproperty
  a_slave_disable_ignored: assert property (p_slave_disable_ignored) else $error("slave stopped without reset");

  property p_hang;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (hang && state_q == spb_pkg::SPB_IDLE) |=> state_q == spb_pkg::SPB_IDLE;
  endproperty
  a_hang: assert property (p_hang) else $error("transfer started with held cs and fault detect");

  property p_tde_disabled;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!run_q && i_tx_wr && tde_q && !i_soft_reset_bit) |=> tde_q;
  endproperty
  a_tde_disabled: assert property (p_tde_disabled) else $error("disabled write cleared empty flag");

  property p_soft_reset;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_soft_reset_bit |=> !run_q && tde_q && !rdy_q;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not stop port");

  property p_write_taken;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_ok && !i_soft_reset_bit && state_q != spb_pkg::SPB_LOAD && !(!i_master_mode && ss_fall)) |=> !tde_q;
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("running write left empty flag set");

  sequence s_start;
    state_q == spb_pkg::SPB_LOAD ##1 state_q == spb_pkg::SPB_SHIFT;
  endsequence
  property p_start;
    @(posedge i_ref_clk) disable iff (!i_rst_n || i_soft_reset_bit)
      (state_q == spb_pkg::SPB_IDLE && run_q && i_master_mode && !tde_q && !hang) |=> s_start;
  endproperty
  a_start: assert property (p_start) else $error("pending transfer did not start");

  property p_extra_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == spb_pkg::SPB_LOAD && glitch && !i_soft_reset_bit) |=> extra_q;
  endproperty
  a_extra_pulse: assert property (p_extra_pulse) else $error("extra clock pulse not armed");

  property p_false_ready;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!i_master_mode && i_enable && !run_q && sck_s && !i_soft_reset_bit) |=> rdy_q;
  endproperty
  a_false_ready: assert property (p_false_ready) else $error("slave enable did not raise ready");
endmodule

// File: bench/spb_peer.sv
// external slave device on chip select 0
`timescale 1ns/1ps
module spb_peer
(
  input  wire logic       i_sck,
  input  wire logic [3:0] i_cs_n,
  output logic            o_miso
);
  logic [7:0] sh_q = 8'ha5;
  always @(i_sck)
    if (!i_cs_n[0])
      sh_q <= {sh_q[6:0], ~sh_q[7]};
  // deselected: show the inverse so no stale bit is held
  assign o_miso = i_cs_n[0] ? ~sh_q[7] : sh_q[7];
endmodule

// File: bench/spb_port_tb.sv
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module spb_port_tb;
  logic        i_ref_clk = 0, i_rst_n = 0, i_enable = 0, i_soft_reset_bit = 0;
  logic        i_master_mode = 1, i_mode_fault_disable = 1, i_cs_hold_after_transfer = 0;
  logic        i_tx_wr = 0, i_rx_rd = 0, i_sck_pin = 0, i_ss_n_pin = 1, i_mosi_pin = 0;
  logic        i_miso_pin, o_tx_reg_empty_flag, o_rx_ready_flag, o_busy, o_sck, seen;
  logic [1:0]  i_cs_sel = 2'h0;
  logic [3:0]  i_cs_polarity = 4'h0, i_clock_phase_bit = 4'h0, o_cs_n;
  logic [31:0] i_serial_clock_divider = 32'h02020202;
  logic [7:0]  i_tx_data_reg = 8'h3c;
  logic [7:0]  o_rx_holding_reg;
  logic        o_sck_oe, o_mosi_oe, o_miso_oe;
  int          errors = 0, check_count = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  spb_port dut (.i_ref_clk, .i_rst_n, .i_enable, .i_soft_reset_bit, .i_master_mode,
    .i_mode_fault_disable, .i_cs_hold_after_transfer, .i_cs_sel, .i_cs_polarity,
    .i_clock_phase_bit, .i_serial_clock_divider, .i_tx_wr, .i_tx_data_reg, .i_rx_rd,
    .i_sck_pin, .i_ss_n_pin, .i_miso_pin, .i_mosi_pin, .o_tx_reg_empty_flag,
    .o_rx_ready_flag, .o_rx_holding_reg, .o_busy, .o_sck, .o_sck_oe, .o_mosi(),
    .o_mosi_oe, .o_miso(), .o_miso_oe, .o_cs_n);
  spb_peer peer (.i_sck(o_sck), .i_cs_n(o_cs_n), .o_miso(i_miso_pin));

  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic pulse(ref logic p);
    p = 1;
    tick();
    p = 0;
  endtask

  task automatic idle_busy(input int n);
    seen = 0;
    repeat (n)
    begin
      tick();
      seen |= o_busy;
    end
    chk(seen, 0);
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    while (o_rx_ready_flag !== 1'b1 && n < 400)
    begin
      tick();
      n++;
    end
    chk(o_rx_ready_flag, 1);
  endtask

  task automatic read_rx;
    pulse(i_rx_rd);
    tick();
    chk(o_rx_ready_flag, 0);
  endtask

  task automatic srst;
    pulse(i_soft_reset_bit);
    tick();
    chk(o_rx_ready_flag, 0);
    chk(o_tx_reg_empty_flag, 1);
  endtask

  task automatic sbyte;
    repeat (8)
    begin
      i_mosi_pin = ~i_mosi_pin;
      tick(4);
      i_sck_pin = 1;
      tick(4);
      i_sck_pin = 0;
    end
    tick(4);
  endtask

  task automatic t_disabled;
    chk({4'h0, o_cs_n}, 8'h0f);
    repeat (3)
    begin
      pulse(i_tx_wr);
      tick();
    end
    tick(2);
    chk(o_tx_reg_empty_flag, 1);
    i_enable = 1;
    idle_busy(30);
    $display("test disabled done");
  endtask

  task automatic t_master;
    pulse(i_tx_wr);
    tick();
    chk(o_tx_reg_empty_flag, 0);
    chk({6'h00, o_sck_oe, o_mosi_oe}, 8'h03);
    wait_rdy();
    read_rx();
    $display("test master done");
  endtask

  task automatic t_hang;
    i_cs_hold_after_transfer = 1;
    i_mode_fault_disable = 0;
    tick();
    pulse(i_tx_wr);
    idle_busy(100);
    i_enable = 0;
    srst();
    i_mode_fault_disable = 1;
    i_enable = 1;
    tick();
    pulse(i_tx_wr);
    wait_rdy();
    read_rx();
    i_cs_hold_after_transfer = 0;
    $display("test hang done");
  endtask

  task automatic t_slave;
    i_enable = 0;
    i_master_mode = 0;
    tick();
    srst();
    i_sck_pin = 1;
    tick(3);
    i_enable = 1;
    tick();
    chk(o_rx_ready_flag, 1);
    i_sck_pin = 0;
    i_cs_polarity[0] = 1;
    tick();
    i_cs_polarity[0] = 0;
    tick();
    read_rx();
    i_ss_n_pin = 0;
    sbyte();
    wait_rdy();
    chk(o_rx_holding_reg, 8'haa);
    read_rx();
    i_enable = 0;
    tick();
    sbyte();
    wait_rdy();
    chk(o_rx_holding_reg, 8'haa);
    chk({7'h00, o_miso_oe}, 8'h01);
    srst();
    i_ss_n_pin = 1;
    $display("test slave done");
  endtask

  task automatic sck_run(input logic [1:0] first, input logic [7:0] exp);
    int   n;
    int   falls;
    logic last;
    i_cs_sel = first;
    tick(2);
    pulse(i_tx_wr);
    tick();
    i_cs_sel = 2'h0;
    n = 0;
    falls = 0;
    while (o_rx_ready_flag !== 1'b1 && n < 400)
    begin
      last = o_sck;
      tick();
      if (last === 1'b1 && o_sck === 1'b0)
        falls++;
      n++;
    end
    chk(o_rx_ready_flag, 1);
    chk(falls[7:0], exp);
    read_rx();
  endtask

  task automatic t_extra;
    i_master_mode = 1;
    i_enable = 1;
    i_cs_polarity = 4'hf;
    i_serial_clock_divider = 32'h01010101;
    sck_run(2'h0, 8'h08);
    i_serial_clock_divider = 32'h02020201;
    sck_run(2'h1, 8'h09);
    i_cs_polarity = 4'h0;
    i_serial_clock_divider = 32'h02020202;
    $display("test extra pulse done");
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    tick(6);
    i_rst_n = 1;
    t_disabled();
    t_master();
    t_hang();
    t_slave();
    t_extra();
    stop_test();
  end

  initial
  begin
    #200000;
    errors++;
    stop_test();
  end
endmodule
